/* File: logic/pce_pkg.sv */
// package: register map, constants and types of the stream encryptor
package pce_pkg;
   localparam int NS = 4;
   localparam int SID_W = 2;
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_STAT = 8'h04;
   localparam logic [7:0] A_KEY0 = 8'h08;
   localparam logic [7:0] A_KEY1 = 8'h0c;
   localparam logic [7:0] A_KEY2 = 8'h10;
   localparam logic [7:0] A_KEY3 = 8'h14;
   localparam logic [7:0] A_IV_HI = 8'h18;
   localparam logic [7:0] A_IV_LO = 8'h1c;
   localparam logic [7:0] A_STREN = 8'h20;
   localparam logic [7:0] A_NEXTID = 8'h24;
   localparam int C_ENC_EN = 0;
   localparam int C_RX_CAP = 1;
   localparam int C_SKE_DONE = 2;
   localparam int S_KEYED = 0;
   localparam int S_BUSY = 1;
   localparam int S_ALIGN = 2;
   localparam int S_HLEN = 3;
   localparam logic [1:0] CTRL_RST = 2'h0;
   localparam logic [NS-1:0] STREN_RST = 4'h0;
   localparam logic [127:0] KEY_RST = 128'h0;
   localparam logic [63:0] IV_RST = 64'h0;
   // arbitrary value
   localparam logic [127:0] GLOBAL_CONSTANT =
      128'h0123456789abcdeffedcba9876543210;
   // arbitrary value
   localparam logic [31:0] FORMAT_ID = 32'h50435445;
   localparam logic [7:0] DESC_TAG = 8'h05;
   localparam logic [7:0] DESC_LEN = 8'h05;
   localparam logic [7:0] VERSION_BYTE = 8'h20;
   localparam logic [3:0] AES_ROUNDS = 4'ha;
   localparam logic [7:0] RCON_INIT = 8'h01;
   localparam logic [7:0] AES_POLY = 8'h1b;
   localparam logic [7:0] AFFINE_C = 8'h63;
   localparam logic [7:0] MAX_PES_HDR = 8'hb8;
   localparam logic [3:0] LAST_BYTE = 4'hf;
   typedef struct packed {
      logic [7:0] data;
      logic pkt_start;
      logic pes_start;
      logic hdr;
      logic [SID_W-1:0] sid;
   } pce_byte_t;
   typedef enum logic [1:0] {
      ST_PASS = 2'b01,
      ST_AES = 2'b10
   } pce_state_t;
endpackage

/* File: logic/pce_stream_enc.sv */
// module: counter-mode payload encryptor for packetized streams
`timescale 1ns/10ps
module pce_stream_enc (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic in_valid_i,
   input wire pce_pkg::pce_byte_t in_byte_i,
   output logic in_ready_o,
   output logic out_valid_o,
   output pce_pkg::pce_byte_t out_byte_o,
   input wire logic out_ready_i,
   output logic [127:0] hdr_field_o,
   output logic hdr_field_valid_o,
   output logic [55:0] desc_o,
   output logic desc_valid_o
);
   function automatic logic [7:0] gmul(input logic [7:0] a,
                                       input logic [7:0] b);
      logic [7:0] p;
      logic [7:0] t;
      p = 8'h00;
      t = a;
      for (int i = 0; i < 8; i++) begin
         if (b[i]) begin
            p = p ^ t;
         end
         t = {t[6:0], 1'b0} ^ (t[7] ? pce_pkg::AES_POLY : 8'h00);
      end
      return p;
   endfunction

   // inverse as x^254, then affine map
   function automatic logic [7:0] sbox(input logic [7:0] x);
      logic [7:0] r;
      logic [7:0] sq;
      r = 8'h01;
      sq = x;
      for (int i = 0; i < 7; i++) begin
         sq = gmul(sq, sq);
         r = gmul(r, sq);
      end
      return r ^ {r[6:0], r[7]} ^ {r[5:0], r[7:6]} ^ {r[4:0], r[7:5]}
         ^ {r[3:0], r[7:4]} ^ pce_pkg::AFFINE_C;
   endfunction

   function automatic logic [127:0] aes_round(input logic [127:0] s,
      input logic [127:0] rk, input logic last);
      logic [7:0] b [16];
      logic [7:0] m [16];
      logic [127:0] o;
      for (int i = 0; i < 16; i++) begin
         b[i] = sbox(s[8*(15-(4*(((i/4)+(i%4))%4)+(i%4))) +: 8]);
      end
      for (int c = 0; c < 4; c++) begin
         for (int r = 0; r < 4; r++) begin
            m[4*c+r] = gmul(b[4*c+r], 8'h02)
               ^ gmul(b[4*c+(r+1)%4], 8'h03)
               ^ b[4*c+(r+2)%4] ^ b[4*c+(r+3)%4];
         end
      end
      o = 128'h0;
      for (int i = 0; i < 16; i++) begin
         o[8*(15-i) +: 8] = last ? b[i] : m[i];
      end
      return o ^ rk;
   endfunction

   function automatic logic [127:0] key_next(input logic [127:0] k,
                                              input logic [7:0] rc);
      logic [31:0] t;
      logic [127:0] n;
      t = {sbox(k[23:16]) ^ rc, sbox(k[15:8]), sbox(k[7:0]),
           sbox(k[31:24])};
      n[127:96] = k[127:96] ^ t;
      n[95:64] = k[95:64] ^ n[127:96];
      n[63:32] = k[63:32] ^ n[95:64];
      n[31:0] = k[31:0] ^ n[63:32];
      return n;
   endfunction

   function automatic logic [127:0] build_field(input logic [31:0] sc,
                                                 input logic [63:0] bc);
      return {13'h0, sc[31:30], 1'b1, sc[29:15], 1'b1, sc[14:0], 1'b1,
              11'h0, bc[63:60], 1'b1, bc[59:45], 1'b1, bc[44:30], 1'b1,
              bc[29:15], 1'b1, bc[14:0], 1'b1};
   endfunction

   logic pready_r;
   logic pslverr_r;
   logic [31:0] prdata_r;
   logic [1:0] ctrl_r;
   logic [pce_pkg::NS-1:0] stren_r;
   logic [127:0] key_r;
   logic [63:0] iv_random_value_r;
   logic keyed_r;
   logic align_err_r;
   logic hlen_err_r;
   logic [31:0] stream_id_counter_r [pce_pkg::NS];
   logic [pce_pkg::NS-1:0] asg_r;
   logic [31:0] next_id_r;
   logic [63:0] block_counter_r [pce_pkg::NS];
   pce_pkg::pce_state_t st_r;
   pce_pkg::pce_state_t st_nxt;
   logic [127:0] ks_r;
   logic [127:0] rk_r;
   logic [7:0] rc_r;
   logic [3:0] rnd_r;
   logic ks_v_r;
   logic [3:0] idx_r;
   pce_pkg::pce_byte_t hold_r;
   logic hold_v_r;
   logic enc_pkt_r;
   logic [7:0] hlen_r;
   logic in_ready_r;
   logic out_v_r;
   pce_pkg::pce_byte_t out_r;
   logic [127:0] field_r;
   logic field_v_r;
   logic desc_v_r;

   logic acc;
   logic wr;
   logic session_key_exchange;
   logic take;
   logic pay;
   logic need;
   logic emit;
   logic aes_done;
   logic hold_v_nxt;
   logic stat_clr_align;
   logic stat_clr_hlen;
   logic in_enc;
   logic [7:0] ks_byte;
   logic [7:0] enc_data;
   logic [63:0] bc_cur;
   logic [63:0] bc0;
   logic [31:0] sid0;
   logic [31:0] new_id;
   logic [127:0] blk_in;
   logic [127:0] rk_nxt;

   assign acc = psel_i & penable_i & ~pready_r;
   assign wr = acc & pwrite_i;
   assign session_key_exchange = wr & (paddr_i == pce_pkg::A_CTRL)
      & pwdata_i[pce_pkg::C_SKE_DONE];
   assign stat_clr_align = wr & (paddr_i == pce_pkg::A_STAT)
      & pwdata_i[pce_pkg::S_ALIGN];
   assign stat_clr_hlen = wr & (paddr_i == pce_pkg::A_STAT)
      & pwdata_i[pce_pkg::S_HLEN];
   assign take = in_valid_i & in_ready_r;
   assign in_enc = keyed_r & ctrl_r[pce_pkg::C_ENC_EN]
      & stren_r[in_byte_i.sid];
   assign pay = hold_v_r & enc_pkt_r & ~hold_r.hdr;
   assign need = pay & ~ks_v_r;
   assign emit = (st_r == pce_pkg::ST_PASS) & hold_v_r & ~need
      & (~out_v_r | out_ready_i);
   assign aes_done = (st_r == pce_pkg::ST_AES)
      & (rnd_r == pce_pkg::AES_ROUNDS);
   assign hold_v_nxt = take | (hold_v_r & ~emit);
   assign ks_byte = ks_r[8*(4'hf-idx_r) +: 8];
   assign enc_data = hold_r.data ^ ks_byte;
   assign bc_cur = block_counter_r[hold_r.sid];
   assign bc0 = block_counter_r[0];
   assign sid0 = stream_id_counter_r[0];
   assign new_id = asg_r[in_byte_i.sid] ?
      stream_id_counter_r[in_byte_i.sid] : next_id_r;
   assign blk_in = {iv_random_value_r[63:32],
      iv_random_value_r[31:0] ^ stream_id_counter_r[hold_r.sid],
      bc_cur};
   assign rk_nxt = key_next(rk_r, rc_r);

   always_comb begin
      case (st_r)
         pce_pkg::ST_PASS: st_nxt = need ? pce_pkg::ST_AES : st_r;
         pce_pkg::ST_AES: st_nxt = aes_done ? pce_pkg::ST_PASS : st_r;
         default: st_nxt = pce_pkg::ST_PASS;
      endcase
   end

   // apb slave, one wait state
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0;
      end else begin
         pready_r <= acc;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0;
         if (acc) begin
            case (paddr_i)
               pce_pkg::A_CTRL: prdata_r <= {30'h0, ctrl_r};
               pce_pkg::A_STAT: prdata_r <= {28'h0, hlen_err_r,
                  align_err_r, st_r == pce_pkg::ST_AES, keyed_r};
               pce_pkg::A_KEY0, pce_pkg::A_KEY1, pce_pkg::A_KEY2,
               pce_pkg::A_KEY3: prdata_r <= 32'h0;
               pce_pkg::A_IV_HI: prdata_r <= iv_random_value_r[63:32];
               pce_pkg::A_IV_LO: prdata_r <= iv_random_value_r[31:0];
               pce_pkg::A_STREN: prdata_r <= {28'h0, stren_r};
               pce_pkg::A_NEXTID: prdata_r <= next_id_r;
               default: pslverr_r <= 1'b1;
            endcase
         end
      end
   end

   // software registers and sticky errors
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_r <= pce_pkg::CTRL_RST;
         stren_r <= pce_pkg::STREN_RST;
         key_r <= pce_pkg::KEY_RST;
         iv_random_value_r <= pce_pkg::IV_RST;
         keyed_r <= 1'b0;
         align_err_r <= 1'b0;
         hlen_err_r <= 1'b0;
      end else begin
         if (wr) begin
            case (paddr_i)
               pce_pkg::A_CTRL: ctrl_r <= pwdata_i[1:0];
               pce_pkg::A_KEY0: key_r[127:96] <= pwdata_i;
               pce_pkg::A_KEY1: key_r[95:64] <= pwdata_i;
               pce_pkg::A_KEY2: key_r[63:32] <= pwdata_i;
               pce_pkg::A_KEY3: key_r[31:0] <= pwdata_i;
               pce_pkg::A_IV_HI: iv_random_value_r[63:32] <= pwdata_i;
               pce_pkg::A_IV_LO: iv_random_value_r[31:0] <= pwdata_i;
               pce_pkg::A_STREN: stren_r <= pwdata_i[pce_pkg::NS-1:0];
               default: ;
            endcase
         end
         if (session_key_exchange) begin
            keyed_r <= 1'b1;
         end
         if (take && in_byte_i.pkt_start && enc_pkt_r
             && idx_r != 4'h0) begin
            align_err_r <= 1'b1;
         end else if (stat_clr_align) begin
            align_err_r <= 1'b0;
         end
         if (take && in_byte_i.hdr && !in_byte_i.pkt_start
             && hlen_r >= pce_pkg::MAX_PES_HDR) begin
            hlen_err_r <= 1'b1;
         end else if (stat_clr_hlen) begin
            hlen_err_r <= 1'b0;
         end
      end
   end

   // stream ids and block counts
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         asg_r <= '0;
         next_id_r <= 32'h0;
         for (int i = 0; i < pce_pkg::NS; i++) begin
            stream_id_counter_r[i] <= 32'h0;
            block_counter_r[i] <= 64'h0;
         end
      end else if (session_key_exchange) begin
         asg_r <= '0;
         next_id_r <= 32'h0;
         for (int i = 0; i < pce_pkg::NS; i++) begin
            stream_id_counter_r[i] <= 32'h0;
            block_counter_r[i] <= 64'h0;
         end
      end else begin
         if (take && in_byte_i.pes_start && in_enc
             && !asg_r[in_byte_i.sid]) begin
            stream_id_counter_r[in_byte_i.sid] <= next_id_r;
            asg_r[in_byte_i.sid] <= 1'b1;
            next_id_r <= next_id_r + 32'h1;
         end
         if (aes_done) begin
            block_counter_r[hold_r.sid] <= bc_cur + 64'h1;
         end
      end
   end

   // aes engine, one round per cycle
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_r <= pce_pkg::ST_PASS;
         ks_r <= 128'h0;
         rk_r <= 128'h0;
         rc_r <= pce_pkg::RCON_INIT;
         rnd_r <= 4'h0;
      end else begin
         st_r <= st_nxt;
         if (st_r == pce_pkg::ST_PASS && need) begin
            rk_r <= key_r ^ pce_pkg::GLOBAL_CONSTANT;
            ks_r <= blk_in ^ key_r ^ pce_pkg::GLOBAL_CONSTANT;
            rc_r <= pce_pkg::RCON_INIT;
            rnd_r <= 4'h1;
         end else if (st_r == pce_pkg::ST_AES) begin
            ks_r <= aes_round(ks_r, rk_nxt, aes_done);
            rk_r <= rk_nxt;
            rc_r <= gmul(rc_r, 8'h02);
            rnd_r <= rnd_r + 4'h1;
         end
      end
   end

   // byte path: hold, encrypt, emit
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hold_r <= '0;
         hold_v_r <= 1'b0;
         in_ready_r <= 1'b0;
         out_r <= '0;
         out_v_r <= 1'b0;
         ks_v_r <= 1'b0;
         idx_r <= 4'h0;
         enc_pkt_r <= 1'b0;
         hlen_r <= 8'h0;
      end else begin
         hold_v_r <= hold_v_nxt;
         in_ready_r <= ~hold_v_nxt;
         if (out_ready_i) begin
            out_v_r <= 1'b0;
         end
         if (aes_done) begin
            ks_v_r <= 1'b1;
         end
         if (take) begin
            hold_r <= in_byte_i;
            if (in_byte_i.pkt_start) begin
               idx_r <= 4'h0;
               ks_v_r <= 1'b0;
               enc_pkt_r <= in_enc;
               hlen_r <= {7'h0, in_byte_i.hdr};
            end else if (in_byte_i.hdr) begin
               hlen_r <= hlen_r + 8'h1;
            end
         end
         if (emit) begin
            out_v_r <= 1'b1;
            out_r <= hold_r;
            if (pay) begin
               out_r.data <= enc_data;
               idx_r <= idx_r + 4'h1;
               if (idx_r == pce_pkg::LAST_BYTE) begin
                  ks_v_r <= 1'b0;
               end
            end
         end
      end
   end

   // header field and descriptor
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         field_r <= 128'h0;
         field_v_r <= 1'b0;
         desc_v_r <= 1'b0;
      end else begin
         if (take && in_byte_i.pes_start) begin
            field_r <= build_field(new_id,
               block_counter_r[in_byte_i.sid]);
            field_v_r <= in_enc;
         end
         desc_v_r <= keyed_r & ctrl_r[pce_pkg::C_RX_CAP];
      end
   end

   assign prdata_o = prdata_r;
   assign pready_o = pready_r;
   assign pslverr_o = pslverr_r;
   assign in_ready_o = in_ready_r;
   assign out_valid_o = out_v_r;
   assign out_byte_o = out_r;
   assign hdr_field_o = field_r;
   assign hdr_field_valid_o = field_v_r;
   assign desc_valid_o = desc_v_r;
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         desc_o <= 56'h0;
      end else begin
         desc_o <= {pce_pkg::DESC_TAG, pce_pkg::DESC_LEN,
            pce_pkg::FORMAT_ID, pce_pkg::VERSION_BYTE};
      end
   end

   property p_blk_step;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (aes_done && !session_key_exchange) |=> bc_cur == $past(bc_cur) + 64'h1;
   endproperty
   a_blk_step: assert property (p_blk_step)
      else $error("block count did not step after keystream");

   property p_id_hold;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (asg_r[0] && !session_key_exchange) |=> $stable(sid0);
   endproperty
   a_id_hold: assert property (p_id_hold)
      else $error("assigned stream id changed");

   property p_bc_idle;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (st_r == pce_pkg::ST_PASS && !session_key_exchange) |=> $stable(bc0);
   endproperty
   a_bc_idle: assert property (p_bc_idle)
      else $error("block count moved without a keystream");

   property p_hdr_clear;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (emit && !pay) |=> out_byte_o.data == $past(hold_r.data);
   endproperty
   a_hdr_clear: assert property (p_hdr_clear)
      else $error("clear byte was altered");

   property p_enc_byte;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (emit && pay) |=> out_byte_o.data == $past(enc_data);
   endproperty
   a_enc_byte: assert property (p_enc_byte)
      else $error("payload byte not xored with keystream byte");

   property p_markers;
      @(posedge mclk_i) disable iff (!rst_n_i)
      $changed(hdr_field_o) |-> (hdr_field_o[127:115] == 13'h0
         && hdr_field_o[79:69] == 11'h0 && hdr_field_o[112]
         && hdr_field_o[96] && hdr_field_o[80] && hdr_field_o[64]
         && hdr_field_o[48] && hdr_field_o[32] && hdr_field_o[16]
         && hdr_field_o[0]);
   endproperty
   a_markers: assert property (p_markers)
      else $error("header field marker or reserved bit wrong");

   property p_no_key;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (take && in_byte_i.pkt_start && !keyed_r) |=> !enc_pkt_r;
   endproperty
   a_no_key: assert property (p_no_key)
      else $error("encryption enabled before key exchange");

   property p_realign;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (take && in_byte_i.pkt_start) |=> (idx_r == 4'h0 && !ks_v_r);
   endproperty
   a_realign: assert property (p_realign)
      else $error("keystream carried across a packet");

   property p_desc;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (!keyed_r || !ctrl_r[pce_pkg::C_RX_CAP]) |=> !desc_valid_o;
   endproperty
   a_desc: assert property (p_desc)
      else $error("descriptor offered to an unconfirmed receiver");
endmodule

/* File: tb/pce_sink.sv */
// downstream multiplexer model with optional back-pressure
`timescale 1ns/10ps
module pce_sink (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic slow_i,
   output logic out_ready_o
);
   logic [1:0] cnt_r;
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_r <= 2'h0;
      end else begin
         cnt_r <= cnt_r + 2'h1;
      end
   end
   // when slow, accepts one cycle in four
   assign out_ready_o = !slow_i || (cnt_r == 2'h3);
endmodule

/* File: tb/test_pce_stream_enc.sv */
// self-checking bench of the stream encryptor
`timescale 1ns/10ps
module test_pce_stream_enc;
   logic mclk_i, rst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
   logic in_valid_i, in_ready_o, out_valid_o, out_ready_i, slow, err;
   logic hdr_field_valid_o, desc_valid_o;
   logic [7:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, seed, rd;
   logic [127:0] hdr_field_o;
   logic [55:0] desc_o;
   pce_pkg::pce_byte_t in_byte_i, out_byte_o;
   pce_pkg::pce_byte_t q[$];
   pce_pkg::pce_byte_t note;
   logic [31:0] kw [6];
   int fail_count, comparisons, cycles;

   pce_stream_enc DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
      .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .in_valid_i(in_valid_i), .in_byte_i(in_byte_i),
      .in_ready_o(in_ready_o), .out_valid_o(out_valid_o),
      .out_byte_o(out_byte_o), .out_ready_i(out_ready_i),
      .hdr_field_o(hdr_field_o), .hdr_field_valid_o(hdr_field_valid_o),
      .desc_o(desc_o), .desc_valid_o(desc_valid_o));
   pce_sink u_sink (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .slow_i(slow),
      .out_ready_o(out_ready_i));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction

   // expected counter field: sliced counters, markers, reserved zeros
   function automatic logic [127:0] fld(input logic [31:0] s,
                                        input logic [63:0] c);
      return {13'h0, s[31:30], 1'b1, s[29:15], 1'b1, s[14:0], 1'b1, 11'h0,
         c[63:60], 1'b1, c[59:45], 1'b1, c[44:30], 1'b1, c[29:15], 1'b1,
         c[14:0], 1'b1};
   endfunction

   // reference cipher: field product, inverse by search, byte-wise rounds
   function automatic logic [7:0] mul(input logic [7:0] a,
                                      input logic [7:0] b);
      logic [7:0] p;
      p = 8'h00;
      for (int i = 7; i >= 0; i--) begin
         p = {p[6:0], 1'b0} ^ (p[7] ? 8'h1b : 8'h00) ^ (b[i] ? a : 8'h00);
      end
      return p;
   endfunction

   function automatic logic [7:0] sb(input logic [7:0] x);
      logic [7:0] v;
      logic [7:0] s;
      v = 8'h00;
      for (int i = 1; i < 256; i++) begin
         if (mul(x, 8'(i)) == 8'h01) begin
            v = 8'(i);
         end
      end
      s = 8'h63;
      for (int k = 0; k < 5; k++) begin
         s = s ^ 8'((v << k) | (v >> (8 - k)));
      end
      return s;
   endfunction

   function automatic logic [127:0] aes(input logic [127:0] key,
                                        input logic [127:0] blk);
      logic [127:0] k;
      logic [7:0] s [16];
      logic [7:0] t [16];
      logic [31:0] w;
      logic [7:0] rc;
      logic [127:0] o;
      int c;
      k = key;
      rc = 8'h01;
      for (int i = 0; i < 16; i++) begin
         s[i] = blk[127 - 8 * i -: 8] ^ k[127 - 8 * i -: 8];
      end
      for (int r = 1; r < 11; r++) begin
         w = {sb(k[23:16]) ^ rc, sb(k[15:8]), sb(k[7:0]), sb(k[31:24])};
         k[127:96] = k[127:96] ^ w;
         k[95:64] = k[95:64] ^ k[127:96];
         k[63:32] = k[63:32] ^ k[95:64];
         k[31:0] = k[31:0] ^ k[63:32];
         rc = mul(rc, 8'h02);
         for (int i = 0; i < 16; i++) begin
            t[i] = sb(s[(i + 4 * (i % 4)) % 16]);
         end
         for (int i = 0; i < 16; i++) begin
            c = i - i % 4;
            s[i] = t[i];
            if (r < 10) begin
               s[i] = mul(t[i], 8'h02) ^ mul(t[c + (i + 1) % 4], 8'h03)
                  ^ t[c + (i + 2) % 4] ^ t[c + (i + 3) % 4];
            end
            s[i] = s[i] ^ k[127 - 8 * i -: 8];
         end
      end
      for (int i = 0; i < 16; i++) begin
         o[127 - 8 * i -: 8] = s[i];
      end
      return o;
   endfunction

   task automatic check_val(input string n, input logic [127:0] e,
                            input logic [127:0] g);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask

   task automatic results();
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge mclk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge mclk_i);
      penable_i <= 1'b1;
      do @(posedge mclk_i); while (pready_o !== 1'b1);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask

   // one packet: nh header bytes then np payload bytes
   task automatic pkt(input logic [1:0] sid, input int nh, input int np,
                      input logic enc, input logic [31:0] id,
                      input logic [63:0] bc);
      pce_pkg::pce_byte_t n;
      logic [127:0] ks;
      ks = 128'h0;
      slow <= seed[31];
      for (int i = 0; i < nh + np; i++) begin
         seed = xs(seed);
         n.data = seed[7:0];
         n.pkt_start = (i == 0);
         n.pes_start = (i == 0);
         n.hdr = (i < nh);
         n.sid = sid;
         in_valid_i <= 1'b1;
         in_byte_i <= n;
         if (enc && !n.hdr && (i - nh) % 16 == 0) begin
            ks = aes({kw[0], kw[1], kw[2], kw[3]} ^ pce_pkg::GLOBAL_CONSTANT,
               {kw[4], kw[5] ^ id, bc + 64'((i - nh) / 16)});
         end
         if (enc && !n.hdr) begin
            n.data = n.data ^ ks[127 - 8 * ((i - nh) % 16) -: 8];
         end
         do @(posedge mclk_i); while (in_ready_o !== 1'b1);
         q.push_back(n);
      end
      in_valid_i <= 1'b0;
      while (q.size() != 0) @(posedge mclk_i);
      repeat (2) @(posedge mclk_i);
      check_val("field_valid", 128'(enc), 128'(hdr_field_valid_o));
      if (enc) check_val("field", fld(id, bc), hdr_field_o);
   endtask

   initial begin
      mclk_i = 1'b0;
      forever #20 mclk_i = ~mclk_i;
   end

   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 30000) begin
         fail_count++;
         $display("MISMATCH timeout exp done got hang");
         results();
      end
   end

   always @(posedge mclk_i) begin
      if (rst_n_i === 1'b1 && out_valid_o === 1'b1
          && out_ready_i === 1'b1) begin
         if (q.size() == 0) begin
            fail_count++;
            $display("MISMATCH out_byte exp none got %h", out_byte_o);
         end else begin
            note = q.pop_front();
            check_val("out_flags", 128'(note[4:0]),
               128'(out_byte_o[4:0]));
            check_val("out_data", 128'(note.data),
               128'(out_byte_o.data));
         end
      end
   end

   initial begin
      rst_n_i = 1'b0;
      {psel_i, penable_i, pwrite_i, in_valid_i, slow} = 5'h0;
      paddr_i = 8'h0;
      pwdata_i = 32'h0;
      in_byte_i = '0;
      seed = 32'hf999ecbd;
      repeat (16) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      @(posedge mclk_i);
      check_val("desc_valid", 128'h0, 128'(desc_valid_o));
      apb(1'b0, pce_pkg::A_CTRL, 32'h0);
      check_val("ctrl_rst", 128'h0, 128'(rd));
      apb(1'b0, pce_pkg::A_STAT, 32'h0);
      check_val("stat_rst", 128'h0, 128'(rd));
      apb(1'b0, 8'h40, 32'h0);
      check_val("unmapped_err", 128'h1, 128'(err));
      check_val("unmapped_data", 128'h0, 128'(rd));
      apb(1'b1, pce_pkg::A_CTRL, 32'h1);
      pkt(2'h0, 6, 20, 1'b0, 32'h0, 64'h0);
      for (int i = 0; i < 6; i++) begin
         seed = xs(seed);
         kw[i] = seed;
         apb(1'b1, pce_pkg::A_KEY0 + 8'(4 * i), seed);
      end
      apb(1'b0, pce_pkg::A_KEY0, 32'h0);
      check_val("key_read", 128'h0, 128'(rd));
      apb(1'b1, pce_pkg::A_STREN, 32'h3);
      apb(1'b1, pce_pkg::A_CTRL, 32'h7);
      @(posedge mclk_i);
      check_val("desc_valid", 128'h1, 128'(desc_valid_o));
      check_val("desc", 128'({pce_pkg::DESC_TAG, pce_pkg::DESC_LEN, pce_pkg::FORMAT_ID, pce_pkg::VERSION_BYTE}), 128'(desc_o));
      pkt(2'h0, 6, 20, 1'b1, 32'h0, 64'h0);
      pkt(2'h1, 9, 16, 1'b1, 32'h1, 64'h0);
      apb(1'b0, pce_pkg::A_STAT, 32'h0);
      check_val("stat_align", 128'h5, 128'(rd));
      apb(1'b1, pce_pkg::A_STAT, 32'h4);
      apb(1'b0, pce_pkg::A_STAT, 32'h0);
      check_val("stat_clear", 128'h1, 128'(rd));
      pkt(2'h0, 4, 16, 1'b1, 32'h0, 64'h2);
      pkt(2'h2, 5, 16, 1'b0, 32'h0, 64'h0);
      apb(1'b0, pce_pkg::A_NEXTID, 32'h0);
      check_val("next_id", 128'h2, 128'(rd));
      apb(1'b1, pce_pkg::A_CTRL, 32'h2);
      pkt(2'h0, 4, 16, 1'b0, 32'h0, 64'h0);
      apb(1'b1, pce_pkg::A_CTRL, 32'h3);
      pkt(2'h0, 4, 16, 1'b1, 32'h0, 64'h3);
      apb(1'b1, pce_pkg::A_CTRL, 32'h7);
      pkt(2'h1, 4, 16, 1'b1, 32'h0, 64'h0);
      results();
   end
endmodule
